/* design/step_dir_consts.vh */
// Constants for the step and direction output stage
`ifndef STEP_DIR_CONSTS_VH
`define STEP_DIR_CONSTS_VH
// Byte addresses of registers
`define ADDR_GENERAL_CONFIGURATION 8'h00
`define ADDR_STEP_PULSE_TIMING 8'h40
`define ADDR_RAMP_PROFILE_SELECT 8'h80
`define ADDR_CURRENT_POSITION 8'h84
`define ADDR_CURRENT_VELOCITY 8'h88
`define ADDR_VELOCITY_LIMIT 8'h90
`define ADDR_TARGET_POSITION 8'hdc
`define ADDR_STATUS 8'hfc
// Register indices as printed
`define IDX_GENERAL_CONFIGURATION 8'h00
`define IDX_STEP_PULSE_TIMING 8'h10
`define IDX_RAMP_PROFILE_SELECT 8'h20
`define IDX_CURRENT_POSITION 8'h21
`define IDX_CURRENT_VELOCITY 8'h22
`define IDX_VELOCITY_LIMIT 8'h24
`define IDX_TARGET_POSITION 8'h37
// Field positions
`define BIT_STEP_INACTIVE_POL 3
`define BIT_TOGGLE_STEP 4
`define BIT_DIR_POLARITY 5
`define BIT_REVERSE_MOTOR_DIR 28
`define BIT_POSITIONING 2
// Reset values
`define RESET_GENERAL_CONFIGURATION 32'h0000_0020
`define RESET_STEP_PULSE_TIMING 32'h0000_0000
// Ramp profiles (low two bits)
`define PROFILE_NONE 2'h0
`define PROFILE_TRAPEZOID 2'h1
`define PROFILE_S_SHAPE 2'h2
// Step rate divider period in clock cycles
`define RATE_PERIOD 16'h0100
`endif

/* design/step_pulse_shaper.v */
// Step pulse length and output polarity stage
`default_nettype none
module step_pulse_shaper (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire fire,
    input wire [15:0] extension,
    input wire inactive_pol,
    input wire toggle_mode,
    // Status
    output wire busy,
    output wire hold,
    output reg step_pulse_output
);
    reg [16:0] count;
    reg [16:0] hold_count;
    reg toggle_level;
    wire active = (count != 17'h0_0000);
    assign busy = active;
    assign hold = (hold_count != 17'h0_0000);
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= 17'h0_0000;
            hold_count <= 17'h0_0000;
            toggle_level <= 1'b0;
            step_pulse_output <= 1'b0;
        end else begin
            if (fire && !active) begin
                count <= {1'b0, extension} + 17'h0_0001;
                toggle_level <= ~toggle_level;
            end else if (active) begin
                count <= count - 17'h0_0001;
                if (count == 17'h0_0001)
                    hold_count <= {1'b0, extension} + 17'h0_0001;
            end
            if (!(fire && !active) && !active && hold)
                hold_count <= hold_count - 17'h0_0001;
            if (toggle_mode)
                step_pulse_output <= (fire && !active) ? ~toggle_level : toggle_level;
            else
                step_pulse_output <= ((fire && !active) || (active && count != 17'h0_0001))
                    ^ inactive_pol;
        end
    end
endmodule
`default_nettype wire

/* design/step_dir_output.v */
// Step and direction output stage with AXI4-Lite registers
`include "step_dir_consts.vh"
`default_nettype none
module step_dir_output (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Driver pins
    output wire step_pulse_output,
    output reg direction_output,
    // Profile status
    output wire positioning_mode,
    output wire [1:0] ramp_profile
);
    reg [31:0] general_configuration;
    reg [31:0] step_pulse_timing;
    reg [2:0] ramp_profile_select;
    reg [31:0] current_position;
    reg [31:0] current_velocity;
    reg [31:0] velocity_limit;
    reg [31:0] target_position;
    reg [9:0] microstep_counter;
    reg [15:0] setup_count;
    reg [15:0] rate_count;
    reg pending;
    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    wire busy;
    wire hold;
    wire fire;
    wire rate_tick;
    wire want_step;
    wire want_back;
    wire new_dir_level;
    wire dir_change;

    assign positioning_mode = ramp_profile_select[`BIT_POSITIONING];
    assign ramp_profile = ramp_profile_select[1:0];

    // Only the no-ramp behaviour is built: profile 01 and 10 follow the
    // same rate here and are exposed for the ramp engine that consumes them.
    assign rate_tick = (rate_count == 16'h0000);
    // Positioning uses sign of distance, velocity mode the velocity sign
    assign want_step = positioning_mode ?
        (current_position != target_position) && (velocity_limit != 32'h0000_0000) :
        (current_velocity != 32'h0000_0000);
    assign want_back = positioning_mode ?
        ($signed(target_position) < $signed(current_position)) :
        current_velocity[31];
    // Sine table walk direction, swapped by the reverse bit
    wire table_back = want_back ^ general_configuration[`BIT_REVERSE_MOTOR_DIR];
    // Direction pin tracks table movement: high means backward unless polarity cleared
    assign new_dir_level = general_configuration[`BIT_DIR_POLARITY] ? table_back : ~table_back;
    assign dir_change = pending && (new_dir_level != direction_output);
    assign fire = pending && !dir_change && (setup_count == 16'h0000) && !busy;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rate_count <= 16'h0000;
            pending <= 1'b0;
            direction_output <= 1'b0;
            setup_count <= 16'h0000;
            current_position <= 32'h0000_0000;
            microstep_counter <= 10'h000;
        end else begin
            rate_count <= rate_tick ? (`RATE_PERIOD - 16'h0001) : (rate_count - 16'h0001);
            if (rate_tick && want_step && !pending) begin
                pending <= 1'b1;
            end
            // Direction may only move once the pulse and its hold window are over
            if (dir_change && !busy && !hold) begin
                direction_output <= new_dir_level;
                setup_count <= step_pulse_timing[31:16];
            end else if (setup_count != 16'h0000) begin
                setup_count <= setup_count - 16'h0001;
            end
            if (fire) begin
                pending <= 1'b0;
                // Fire only happens once the pin agrees with the table walk, so the
                // counter follows the pin even if velocity flipped while the step waited
                if (table_back) begin
                    microstep_counter <= microstep_counter - 10'h001;
                    current_position <= current_position - 32'h0000_0001;
                end else begin
                    microstep_counter <= microstep_counter + 10'h001;
                    current_position <= current_position + 32'h0000_0001;
                end
            end
            if (aw_held && w_held && !s_axi_bvalid && aw_addr == `ADDR_CURRENT_POSITION)
                current_position <= w_data;
        end
    end

    step_pulse_shaper shaper (
        .aclk(aclk),
        .aresetn(aresetn),
        .fire(fire),
        .extension(step_pulse_timing[15:0]),
        .inactive_pol(general_configuration[`BIT_STEP_INACTIVE_POL]),
        .toggle_mode(general_configuration[`BIT_TOGGLE_STEP]),
        .busy(busy),
        .hold(hold),
        .step_pulse_output(step_pulse_output)
    );

    // Write side: address and data latched independently, response after both
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = data[i*8 +: 8];
        end
    endfunction
    wire known_w = (aw_addr == `ADDR_GENERAL_CONFIGURATION) ||
        (aw_addr == `ADDR_STEP_PULSE_TIMING) || (aw_addr == `ADDR_RAMP_PROFILE_SELECT) ||
        (aw_addr == `ADDR_CURRENT_POSITION) || (aw_addr == `ADDR_CURRENT_VELOCITY) ||
        (aw_addr == `ADDR_VELOCITY_LIMIT) || (aw_addr == `ADDR_TARGET_POSITION);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            general_configuration <= `RESET_GENERAL_CONFIGURATION;
            step_pulse_timing <= `RESET_STEP_PULSE_TIMING;
            ramp_profile_select <= 3'h0;
            current_velocity <= 32'h0000_0000;
            velocity_limit <= 32'h0000_0000;
            target_position <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_addr <= s_axi_awaddr & 8'hfc;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && !w_held) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_w ? 2'h0 : 2'h2;
                case (aw_addr)
                    `ADDR_GENERAL_CONFIGURATION: general_configuration <=
                        merge(general_configuration, w_data, w_strb);
                    `ADDR_STEP_PULSE_TIMING: step_pulse_timing <=
                        merge(step_pulse_timing, w_data, w_strb);
                    `ADDR_RAMP_PROFILE_SELECT: if (w_strb[0])
                        ramp_profile_select <= w_data[2:0];
                    `ADDR_CURRENT_VELOCITY: current_velocity <=
                        merge(current_velocity, w_data, w_strb);
                    `ADDR_VELOCITY_LIMIT: velocity_limit <=
                        merge(velocity_limit, w_data, w_strb);
                    `ADDR_TARGET_POSITION: target_position <=
                        merge(target_position, w_data, w_strb);
                    default: ;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // Read side: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr & 8'hfc)
                `ADDR_GENERAL_CONFIGURATION: s_axi_rdata <= general_configuration;
                `ADDR_STEP_PULSE_TIMING: s_axi_rdata <= step_pulse_timing;
                `ADDR_RAMP_PROFILE_SELECT: s_axi_rdata <= {29'h0, ramp_profile_select};
                `ADDR_CURRENT_POSITION: s_axi_rdata <= current_position;
                `ADDR_CURRENT_VELOCITY: s_axi_rdata <= current_velocity;
                `ADDR_VELOCITY_LIMIT: s_axi_rdata <= velocity_limit;
                `ADDR_TARGET_POSITION: s_axi_rdata <= target_position;
                `ADDR_STATUS: s_axi_rdata <= {16'h0000, 2'h0, microstep_counter,
                    busy, hold, pending, direction_output};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/step_dir_monitor.sv */
// Bus and pin checks for the step and direction output stage
`default_nettype none
module step_dir_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic step_pulse_output,
    input wire logic direction_output,
    input wire logic positioning_mode,
    input wire logic [1:0] ramp_profile
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_done;
        s_axi_bvalid && s_axi_bready ##1 !s_axi_bvalid;
    endsequence
    sequence r_done;
        s_axi_rvalid && s_axi_rready ##1 !s_axi_rvalid;
    endsequence
    // Address and data are latched first, the response comes one edge later
    write_answer_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    write_close_a: assert property (s_axi_bvalid && s_axi_bready |-> b_done)
        else $error("write response not withdrawn");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    read_refuse_a: assert property (s_axi_rvalid && s_axi_rready |-> !s_axi_arready ##0 r_done)
        else $error("read answer not withdrawn");
    unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    dir_hold_a: assert property ($changed(step_pulse_output) |=> $stable(direction_output))
        else $error("direction moved next to a step edge");
    mode_write_a: assert property ($changed({positioning_mode, ramp_profile}) |->
        $rose(s_axi_bvalid))
        else $error("profile changed without a write");
endmodule
`default_nettype wire

/* tb/driver_model.sv */
// Stepper driver model that counts the steps it sees on its pins
`default_nettype none
module driver_model (
    // Pins
    input wire logic aclk,
    input wire logic step,
    // Mode, as the driver is strapped
    input wire logic falling,
    input wire logic toggle,
    // Count
    output int steps
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last = 1'b0;
    int seen = 0;
    assign steps = seen;
    always @(posedge aclk) begin
        last <= step;
        if (step != last && (toggle || step != falling)) begin
            seen <= seen + 1;
        end
    end
endmodule
`default_nettype wire

/* tb/step_dir_output_test.sv */
// Self-checking bench for the step and direction output stage
`include "step_dir_consts.vh"
`default_nettype none
module step_dir_output_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] gen_a = `ADDR_GENERAL_CONFIGURATION;
    localparam logic [7:0] tim_a = `ADDR_STEP_PULSE_TIMING;
    localparam logic [7:0] ramp_a = `ADDR_RAMP_PROFILE_SELECT;
    localparam logic [7:0] pos_a = `ADDR_CURRENT_POSITION;
    localparam logic [7:0] vel_a = `ADDR_CURRENT_VELOCITY;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, step, dir, pmode;
    logic mon = 1'b0, pol = 1'b0, tog = 1'b0, ps = 1'b0, pd = 1'b0;
    logic [1:0] bresp, rresp, prof, r;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int steps, fail_count, checks, since_step, since_dir, ext, setup, p;
    step_dir_output i_step_dir_output (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .step_pulse_output(step), .direction_output(dir),
        .positioning_mode(pmode), .ramp_profile(prof)
    );
    driver_model i_driver_model (.aclk(aclk), .step(step), .falling(pol), .toggle(tog),
        .steps(steps));
    always #2.5 aclk = ~aclk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Ready is judged at the falling edge, where it equals what the next rising edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        cmp(bresp, 0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            v = rdata;
            e = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        rd(a, d, r);
        cmp(d, v);
        cmp(r, e);
    endtask
    task automatic wsteps(input int n);
        int s;
        s = steps;
        while (steps < s + n) @(posedge aclk);
    endtask
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Cycle distances between pin edges, taken where everything has settled
    always @(negedge aclk) begin
        ps <= step;
        pd <= dir;
        since_step <= (step != ps) ? 0 : since_step + 1;
        since_dir <= (dir != pd) ? 0 : since_dir + 1;
        if (mon && dir != pd) cmp(since_step >= ext, 1);
        if (mon && step && !ps) cmp(since_dir + 1 >= setup, 1);
        if (mon && !step && ps) cmp(since_step, ext);
    end
    initial begin
        #100000;
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(gen_a, 32'h0000_0020, 2'h0);
        rc(tim_a, 32'h0000_0000, 2'h0);
        rc(8'h04, 32'h0000_0000, 2'h2);
        foreach (codes[i]) begin
            wr(ramp_a, {29'h0, codes[i]});
            rc(ramp_a, {29'h0, codes[i]}, 2'h0);
            cmp({pmode, prof}, codes[i]);
        end
        wr(ramp_a, 32'h0000_0000);
        // A long pulse makes the hold window reach past the next rate tick
        ext = 150;
        setup = 5;
        wr(tim_a, 32'h0005_0096);
        mon <= 1'b1;
        wr(vel_a, 32'h0000_0001);
        wsteps(4);
        cmp(dir, 0);
        rc(pos_a, steps, 2'h0);
        p = steps;
        // Reversal: the blocked step must come out late, so the count still matches
        wr(vel_a, 32'hffff_ffff);
        wsteps(3);
        cmp(dir, 1);
        rc(pos_a, 2 * p - steps, 2'h0);
        mon <= 1'b0;
        wr(gen_a, 32'h1000_0020);
        wsteps(2);
        cmp(dir, 0);
        wr(gen_a, 32'h1000_0000);
        wsteps(2);
        cmp(dir, 1);
        pol <= 1'b1;
        wr(gen_a, 32'h0000_0028);
        wsteps(3);
        repeat (ext + 3) @(posedge aclk);
        cmp(step, 1);
        wr(gen_a, 32'h0000_0038);
        tog <= 1'b1;
        rd(pos_a, d, r);
        p = steps;
        wsteps(4);
        rc(pos_a, d - 32'(steps - p), 2'h0);
        wr(vel_a, 32'h0000_0000);
        wr(ramp_a, 32'h0000_0004);
        rd(pos_a, d, r);
        p = d;
        wr(`ADDR_TARGET_POSITION, p + 3);
        wr(`ADDR_VELOCITY_LIMIT, 32'hffff_ff00);
        repeat (1500) @(posedge aclk);
        rc(pos_a, p + 3, 2'h0);
        // Position was never written, so the microstep counter walks with it
        rd(`ADDR_STATUS, d, r);
        cmp(d[13:4], 10'(p + 3));
        cmp(r, 2'h0);
        end_sim;
    end
endmodule
bind step_dir_output step_dir_monitor i_step_dir_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .step_pulse_output(step_pulse_output), .direction_output(direction_output),
    .positioning_mode(positioning_mode), .ramp_profile(ramp_profile)
);
`default_nettype wire
